/* design/csp_pkg.sv */
// Package for the charger SMBus register port: addresses, command codes,
// status field positions and carrier types.
// Assumes a single 100 MHz clock and SMBus pins sampled synchronously.
package csp_pkg;
   localparam logic [6:0] CSP_TARGET_ADDR7 = 7'h09; // 8-bit form 8'h12
   localparam logic [7:0] CSP_ADDR8 = 8'h12;
   localparam logic [7:0] CSP_CMD_MODE = 8'h12;
   localparam logic [7:0] CSP_CMD_STATUS = 8'h13;
   localparam logic [7:0] CSP_CMD_ICHG = 8'h14;
   localparam logic [7:0] CSP_CMD_VCHG = 8'h15;
   localparam logic [7:0] CSP_CMD_IIN = 8'h3F;
   localparam logic [15:0] CSP_REG_RESET = 16'h0000;
   localparam int CSP_ST_BAT_CONN = 6;
   localparam int CSP_ST_ADP_CONN = 7;
   localparam int CSP_MODE_LEARN = 0;
   localparam logic [15:0] CSP_READ_UNMAPPED = 16'hFFFF;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] ichg;
      logic [15:0] vchg;
      logic [15:0] iin;
   } csp_regs_s;

   typedef struct packed {
      logic scl_i;
      logic sda_i;
   } csp_pins_s;

   typedef enum logic [2:0] {
      CSP_IDLE = 3'b000,
      CSP_ADDR = 3'b001,
      CSP_ACK = 3'b010,
      CSP_WRB = 3'b011,
      CSP_RDB = 3'b100,
      CSP_RACK = 3'b101,
      CSP_HOLD = 3'b110
   } csp_state_e;
endpackage

/* design/csp_top.sv */
// SMBus target port of a battery charge controller: five 16-bit registers,
// open-drain alert, and adapter/battery system source selection.
// Assumes SCL and SDA are already synchronous to clk (glitch-free).
`timescale 1ns/100ps
module csp_top
   import csp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // SMBus pins, open drain
   input wire csp_pkg::csp_pins_s pins,
   output logic sda_o,
   output logic sda_oe_n,
   output logic alert_o,
   output logic alert_oe_n,
   // Charger state in, selector and settings out
   input wire logic adapter_detect,
   input wire logic [15:0] status_in,
   output logic adapter_sel,
   output logic battery_sel,
   output csp_pkg::csp_regs_s regs
);
   import csp_pkg::*;

   csp_state_e state, next_state;
   logic scl_q, sda_q;
   logic [7:0] shreg, next_shreg;
   logic [2:0] bitcnt, next_bitcnt;
   logic [1:0] bytecnt, next_bytecnt;
   logic rw, next_rw;
   logic [7:0] cmd, next_cmd;
   logic [7:0] wlow, next_wlow;
   logic [15:0] rdata, next_rdata;
   logic sda_drv, next_sda_drv;
   logic st_read, next_st_read;
   csp_regs_s next_regs;
   logic [15:0] status, next_status;
   logic alert, next_alert;
   logic next_adapter_sel, next_battery_sel;

   wire logic scl_rise = pins.scl_i & ~scl_q;
   wire logic scl_fall = ~pins.scl_i & scl_q;
   wire logic start_c = scl_q & pins.scl_i & sda_q & ~pins.sda_i;
   wire logic stop_c = scl_q & pins.scl_i & ~sda_q & pins.sda_i;

   function automatic logic [15:0] rd_sel(input logic [7:0] c,
                                          input csp_regs_s r,
                                          input logic [15:0] s);
      logic [15:0] v;
      v = CSP_READ_UNMAPPED;
      unique case (c)
         CSP_CMD_VCHG: v = r.vchg;
         CSP_CMD_ICHG: v = r.ichg;
         CSP_CMD_IIN: v = r.iin;
         CSP_CMD_MODE: v = r.mode;
         CSP_CMD_STATUS: v = s;
         default: v = CSP_READ_UNMAPPED;
      endcase
      return v;
   endfunction

   // Protocol engine; no PEC byte exists in any frame
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_bytecnt = bytecnt;
      next_rw = rw;
      next_cmd = cmd;
      next_wlow = wlow;
      next_rdata = rdata;
      next_sda_drv = sda_drv;
      next_st_read = 1'b0;
      next_regs = regs;
      if (start_c) begin
         // The SCL fall that closes a start carries no bit, so skip it
         next_state = CSP_HOLD;
         next_bitcnt = 3'h0;
         next_sda_drv = 1'b0;
      end else if (stop_c) begin
         next_state = CSP_IDLE;
         next_sda_drv = 1'b0;
      end else begin
         unique case (state)
            CSP_IDLE: next_sda_drv = 1'b0;
            CSP_HOLD: begin
               if (scl_fall) begin
                  next_state = CSP_ADDR;
                  next_bitcnt = 3'h0;
               end
            end
            CSP_ADDR, CSP_WRB: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], pins.sda_i};
               end
               if (scl_fall) begin
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     if (state == CSP_ADDR) begin
                        if (shreg[7:1] == CSP_TARGET_ADDR7) begin
                           next_rw = shreg[0];
                           next_sda_drv = 1'b1;
                           next_state = CSP_ACK;
                           if (shreg[0]) begin
                              next_bytecnt = 2'h0;
                              next_rdata = rd_sel(cmd, regs, status);
                           end else begin
                              next_bytecnt = 2'h0;
                           end
                        end else begin
                           next_state = CSP_IDLE;
                        end
                     end else begin
                        next_sda_drv = 1'b1;
                        next_state = CSP_ACK;
                        unique case (bytecnt)
                           2'h0: next_cmd = shreg;
                           2'h1: next_wlow = shreg;
                           default: begin
                              unique case (cmd)
                                 CSP_CMD_VCHG:
                                    next_regs.vchg = {shreg, wlow};
                                 CSP_CMD_ICHG:
                                    next_regs.ichg = {shreg, wlow};
                                 CSP_CMD_IIN:
                                    next_regs.iin = {shreg, wlow};
                                 CSP_CMD_MODE:
                                    next_regs.mode = {shreg, wlow};
                                 default: next_regs = regs;
                              endcase
                           end
                        endcase
                        if (bytecnt != 2'h3) begin
                           next_bytecnt = bytecnt + 2'h1;
                        end
                     end
                  end
               end
            end
            CSP_ACK: begin
               if (scl_fall) begin
                  next_bitcnt = 3'h0;
                  if (rw) begin
                     next_state = CSP_RDB;
                     next_sda_drv = ~rdata[7];
                  end else begin
                     next_state = CSP_WRB;
                     next_sda_drv = 1'b0;
                  end
               end
            end
            CSP_RDB: begin
               if (scl_fall) begin
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     next_sda_drv = 1'b0;
                     next_state = CSP_RACK;
                  end else begin
                     next_sda_drv = ~rdata[3'h6 - bitcnt];
                  end
               end
            end
            CSP_RACK: begin
               if (scl_rise) begin
                  next_shreg = {7'h00, pins.sda_i};
               end
               if (scl_fall) begin
                  next_bitcnt = 3'h0;
                  if (bytecnt == 2'h0 && !shreg[0]) begin
                     next_bytecnt = 2'h1;
                     next_rdata = {8'h00, rdata[15:8]};
                     next_state = CSP_RDB;
                     next_sda_drv = ~rdata[15];
                  end else begin
                     // Second byte sent: status read is complete
                     next_st_read = (bytecnt == 2'h0) ? 1'b0 :
                                    (cmd == CSP_CMD_STATUS);
                     if (bytecnt == 2'h0) begin
                        next_st_read = 1'b0;
                     end
                     next_state = CSP_IDLE;
                  end
               end
            end
            default: next_state = CSP_IDLE;
         endcase
      end
   end

   // Source selection and status; alert is cleared by a host status read
   always_comb begin
      next_status = status_in;
      next_adapter_sel = adapter_detect & ~regs.mode[CSP_MODE_LEARN];
      next_battery_sel = ~next_adapter_sel;
      next_status[CSP_ST_BAT_CONN] = battery_sel;
      next_status[CSP_ST_ADP_CONN] = adapter_sel;
      next_alert = alert;
      if (st_read) begin
         next_alert = 1'b0;
      end
      // Change wins over a clear in the same cycle
      if (next_status != status) begin
         next_alert = 1'b1;
      end
   end

   // Registers persist until rewritten; there is no watchdog
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= CSP_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         bytecnt <= 2'h0;
         rw <= 1'b0;
         cmd <= 8'h00;
         wlow <= 8'h00;
         rdata <= 16'h0000;
         sda_drv <= 1'b0;
         st_read <= 1'b0;
         regs <= {4{CSP_REG_RESET}};
         status <= 16'h0000;
         alert <= 1'b0;
         adapter_sel <= 1'b0;
         battery_sel <= 1'b1;
         sda_o <= 1'b0;
         sda_oe_n <= 1'b1;
         alert_o <= 1'b0;
         alert_oe_n <= 1'b1;
      end else begin
         state <= next_state;
         scl_q <= pins.scl_i;
         sda_q <= pins.sda_i;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         bytecnt <= next_bytecnt;
         rw <= next_rw;
         cmd <= next_cmd;
         wlow <= next_wlow;
         rdata <= next_rdata;
         sda_drv <= next_sda_drv;
         st_read <= next_st_read;
         regs <= next_regs;
         status <= next_status;
         alert <= next_alert;
         adapter_sel <= next_adapter_sel;
         battery_sel <= next_battery_sel;
         sda_o <= 1'b0;
         sda_oe_n <= ~next_sda_drv;
         alert_o <= 1'b0;
         alert_oe_n <= ~next_alert;
      end
   end
endmodule

/* test/csp_host.sv */
// Partner model: an SMBus host that bit-bangs SCL and SDA from clk.
// Assumes the bench resolves the open-drain SDA wire and feeds it back.
`timescale 1ns/100ps
module csp_host
   import csp_pkg::*;
(
   // Clock and resolved data wire
   input wire logic clk,
   input wire logic sda_w,
   // Host drive, 1 means released to the pull-up
   output logic scl = 1'b1,
   output logic sda = 1'b1
);
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // SDA moves only while SCL is low, except in start and stop
   task automatic bx(input logic b, output logic r);
      scl <= 1'b0;
      tk(2);
      sda <= b;
      tk(2);
      scl <= 1'b1;
      tk(2);
      r = sda_w;
      tk(2);
   endtask
   // Start or repeated start, or stop; long low phase gives the port time
   task automatic st(input logic stop);
      tk(1);
      scl <= 1'b0;
      tk(2);
      sda <= !stop;
      tk(4);
      scl <= 1'b1;
      tk(2);
      sda <= stop;
      tk(2);
   endtask
   task automatic wb(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bx(d[i], r);
      bx(1'b1, r);
      ack = !r;
   endtask
   task automatic rb(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bx(1'b1, d[i]);
      bx(nack, r);
   endtask
   // No check byte follows the data in either direction
   task automatic ww(input logic [7:0] a, c, input logic [15:0] v,
                     output logic ok);
      logic [3:0] k;
      st(1'b0);
      wb(a, k[0]);
      wb(c, k[1]);
      wb(v[7:0], k[2]);
      wb(v[15:8], k[3]);
      st(1'b1);
      ok = &k;
   endtask
   task automatic rw(input logic [7:0] c, output logic [15:0] v);
      logic k;
      st(1'b0);
      wb(CSP_ADDR8, k);
      wb(c, k);
      st(1'b0);
      wb(CSP_ADDR8 | 8'h01, k);
      rb(1'b0, v[7:0]);
      rb(1'b1, v[15:8]);
      st(1'b1);
   endtask
endmodule

/* test/csp_checker.sv */
// Assertions on the ports of the charger SMBus register port.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module csp_checker
   import csp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bus and alert pins
   input wire csp_pkg::csp_pins_s pins,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic alert_o,
   input wire logic alert_oe_n,
   // Charger side
   input wire logic adapter_detect,
   input wire logic [15:0] status_in,
   input wire logic adapter_sel,
   input wire logic battery_sel,
   input wire csp_pkg::csp_regs_s regs
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sel_exclusive_a: assert property (battery_sel == !adapter_sel)
      else $error("selectors not complementary");
   adp_source_a: assert property (
      (adapter_detect && !regs.mode[CSP_MODE_LEARN])[*2] |-> adapter_sel)
      else $error("adapter not selected");
   learn_battery_a: assert property (
      (adapter_detect && regs.mode[CSP_MODE_LEARN])[*2] |-> battery_sel)
      else $error("learn mode kept adapter");
   no_adp_battery_a: assert property (
      (!adapter_detect)[*2] |-> battery_sel)
      else $error("battery not selected");
   status_alert_a: assert property (
      $changed(status_in & 16'hFF3F) |-> ##[1:3] !alert_oe_n)
      else $error("status change without alert");
   select_alert_a: assert property (
      $changed(adapter_sel) |-> ##[1:3] !alert_oe_n)
      else $error("source change without alert");
   alert_hold_a: assert property (
      !alert_oe_n && pins.scl_i && pins.sda_i |=> !alert_oe_n)
      else $error("alert released on idle bus");
   regs_persist_a: assert property (
      pins.scl_i && pins.sda_i |=> $stable(regs))
      else $error("settings changed on idle bus");
   vchg_reset_a: assert property ($rose(resetn) |-> regs.vchg == 16'h0000)
      else $error("charge voltage not zero");
   open_drain_a: assert property (!sda_o && !alert_o)
      else $error("open-drain pin driven high");
   sda_timing_a: assert property ($changed(sda_oe_n) |-> !pins.scl_i)
      else $error("data changed while clock high");
endmodule
bind csp_top csp_checker csp_checker_inst (.clk, .resetn, .pins, .sda_o,
   .sda_oe_n, .alert_o, .alert_oe_n, .adapter_detect, .status_in,
   .adapter_sel, .battery_sel, .regs);

/* test/csp_top_tb.sv */
// Bench for csp_top: SMBus host model, reference model in an array.
// Assumes pull-ups on SDA and alert; SDA is resolved here.
`timescale 1ns/100ps
module csp_top_tb;
   import csp_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic adp = 1'b0;
   logic [15:0] st = 16'h0000;
   logic scl, sda_h, sda_o, sda_oe_n, alert_o, alert_oe_n, asel, bsel, ok;
   logic [15:0] v;
   logic [7:0] cmds [4] = '{CSP_CMD_MODE, CSP_CMD_ICHG, CSP_CMD_VCHG,
                            CSP_CMD_IIN};
   csp_pins_s pins;
   csp_regs_s regs;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   int mdl [bit [7:0]];
   always #5 clk = ~clk;
   // Open-drain SDA with pull-up: low if either side pulls
   assign pins = {scl, sda_h & sda_oe_n};
   csp_host csp_host_inst (.clk, .sda_w(pins.sda_i), .scl, .sda(sda_h));
   csp_top csp_top_inst (.clk, .resetn, .pins, .sda_o, .sda_oe_n, .alert_o,
      .alert_oe_n, .adapter_detect(adp), .status_in(st),
      .adapter_sel(asel), .battery_sel(bsel), .regs);
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic c16(input logic [15:0] g, e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t word %h expected %h", $time, g, e);
      end
   endtask
   task automatic c1(input logic g, e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t bit %b expected %b", $time, g, e);
      end
   endtask
   function automatic logic lrn();
      return mdl[CSP_CMD_MODE][CSP_MODE_LEARN];
   endfunction
   function automatic logic [15:0] st_exp();
      logic a;
      a = adp && !lrn();
      return {st[15:8], a, !a, st[5:0]};
   endfunction
   task automatic chk_out();
      tk(4);
      c1(asel, adp && !lrn());
      c1(bsel, !adp || lrn());
      c16(regs.mode, 16'(mdl[CSP_CMD_MODE]));
      c16(regs.ichg, 16'(mdl[CSP_CMD_ICHG]));
      c16(regs.vchg, 16'(mdl[CSP_CMD_VCHG]));
      c16(regs.iin, 16'(mdl[CSP_CMD_IIN]));
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      csp_host_inst.ww(CSP_ADDR8, c, d, ok);
      c1(ok, 1'b1);
      if (mdl.exists(c))
         mdl[c] = d;
   endtask
   task automatic rd(input logic [7:0] c);
      csp_host_inst.rw(c, v);
      if (c == CSP_CMD_STATUS)
         c16(v, st_exp());
      else
         c16(v, mdl.exists(c) ? 16'(mdl[c]) : CSP_READ_UNMAPPED);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      logic pb;
      logic nb;
      pb = 1'b1;
      foreach (cmds[i])
         mdl[cmds[i]] = 0;
      void'($urandom(30));
      tk(4);
      resetn <= 1'b1;
      chk_out();
      c1(alert_oe_n, 1'b0);
      rd(CSP_CMD_STATUS);
      tk(4);
      c1(alert_oe_n, 1'b1);
      foreach (cmds[i])
         wr(cmds[i], 16'($urandom()));
      foreach (cmds[i])
         rd(cmds[i]);
      wr(CSP_CMD_STATUS, 16'h1234);
      wr(8'h20, 16'hABCD);
      rd(8'h20);
      csp_host_inst.ww(8'h14, CSP_CMD_ICHG, 16'h5555, ok);
      c1(ok, 1'b0);
      chk_out();
      // Status change with no read: alert must stay, settings untouched
      @(posedge clk);
      st <= st ^ (16'($urandom()) | 16'h0001);
      tk(4);
      c1(alert_oe_n, 1'b0);
      tk(200);
      c1(alert_oe_n, 1'b0);
      chk_out();
      rd(CSP_CMD_STATUS);
      tk(4);
      c1(alert_oe_n, 1'b1);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         adp <= k[0];
         wr(CSP_CMD_MODE, 16'(k[1]));
         chk_out();
         nb = !adp || lrn();
         c1(alert_oe_n, pb == nb);
         pb = nb;
         rd(CSP_CMD_STATUS);
      end
      close_out();
   end
endmodule
